// >>> hdl/coe_regs.sv
/*
 Serial bus slave holding the seven configuration bytes and the six
 clock pair enables. Serial logic runs on the bus clock (sclClk); the
 enables cross to core_clk through two flip-flops each.
 Assumes the bus clock toggles while reset is held, and an external
 pull-up on the data line.
*/
`timescale 1ns/1ps
`include "coe_map.svh"
module coe_regs
    import coe_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic [5:0] clockPairEn
);
    // Bus-clock-side reset, released through two flops
    logic [1:0] sclRstSync_q;
    logic sclRstn;
    always_ff @(posedge sclClk)
    begin
        sclRstSync_q <= {sclRstSync_q[0], resetn};
    end
    assign sclRstn = sclRstSync_q[1];

    // Start/stop detection: sda edges while scl high
    logic startFlag_q;
    logic stopFlag_q;
    logic startClr_q;
    logic stopClr_q;
    always_ff @(negedge sdaIn or posedge startClr_q)
    begin
        if (startClr_q)
            startFlag_q <= 1'b0;
        else
            startFlag_q <= sclClk;
    end
    always_ff @(posedge sdaIn or posedge stopClr_q)
    begin
        if (stopClr_q)
            stopFlag_q <= 1'b0;
        else
            stopFlag_q <= sclClk;
    end

    coe_state_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [2:0] idx_q;
    logic ackPhase_q;
    logic [7:0] enLow_q;
    logic [7:0] enHigh_q;

    function automatic logic [7:0] readByte(input logic [2:0] i, input logic [7:0] lo,
                                            input logic [7:0] hi);
        if (i <= `COE_OFS_RSVD4)
            readByte = `COE_RST_RSVD;
        else if (i == `COE_OFS_ENLOW)
            readByte = lo;
        else if (i == `COE_OFS_ENHIGH)
            readByte = hi;
        else
            readByte = 8'h00;
    endfunction

    logic [7:0] rxByte;
    assign rxByte = {shift_q[6:0], sdaIn};

    function automatic coe_state_t nextState(input coe_state_t s, input logic [7:0] b);
        case (s)
            COE_ADDR:
            begin
                if (b == `COE_ADDR_WRITE)
                    nextState = COE_WCMD;
                else if (b == `COE_ADDR_READ)
                    nextState = COE_RDAT;
                else
                    nextState = COE_IGN;
            end
            COE_WCMD: nextState = COE_WCNT;
            COE_WCNT: nextState = COE_WDAT;
            COE_WDAT: nextState = COE_WDAT;
            COE_RDAT: nextState = COE_RDAT;
            default: nextState = COE_IGN;
        endcase
    endfunction

    // Writable bits from the bus, all other bits forced to their defaults
    function automatic logic [7:0] mergeByte(input logic [7:0] d, input logic [7:0] m,
                                             input logic [7:0] r);
        mergeByte = (d & m) | (r & ~m);
    endfunction

    // Flag clears; held high in reset so the async flags start cleared
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            startClr_q <= 1'b1;
            stopClr_q <= 1'b1;
        end
        else
        begin
            startClr_q <= startFlag_q;
            stopClr_q <= stopFlag_q;
        end
    end

    // Shared strobes of the byte framer
    logic frameLive;
    logic byteDone;
    logic ackEnd;
    logic bitShift;
    logic readAddr;
    assign frameLive = !startFlag_q && !stopFlag_q && state_q != COE_IDLE && state_q != COE_IGN;
    assign byteDone = frameLive && !ackPhase_q && bitCnt_q == 4'h7;
    assign ackEnd = frameLive && ackPhase_q;
    assign bitShift = frameLive && !ackPhase_q && bitCnt_q != 4'h7;
    assign readAddr = state_q == COE_ADDR && rxByte == `COE_ADDR_READ;

    // Transfer state
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            state_q <= COE_IDLE;
        end
        else if (startFlag_q)
        begin
            state_q <= COE_ADDR;
        end
        else if (stopFlag_q)
        begin
            state_q <= COE_IDLE;
        end
        else if (ackEnd && state_q == COE_RDAT && sdaIn)
        begin
            state_q <= COE_IGN;
        end
        else if (byteDone)
        begin
            state_q <= nextState(state_q, rxByte);
        end
    end

    // Bit counter and acknowledge slot
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            bitCnt_q <= 4'h0;
            ackPhase_q <= 1'b0;
        end
        else if (startFlag_q)
        begin
            bitCnt_q <= 4'h1;
            ackPhase_q <= 1'b0;
        end
        else if (ackEnd)
        begin
            bitCnt_q <= 4'h0;
            ackPhase_q <= 1'b0;
        end
        else if (byteDone)
        begin
            bitCnt_q <= 4'h8;
            ackPhase_q <= 1'b1;
        end
        else if (bitShift)
        begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // Receive shifter, MSB first
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            shift_q <= 8'h00;
        end
        else if (startFlag_q)
        begin
            shift_q <= {7'h00, sdaIn};
        end
        else if (bitShift)
        begin
            shift_q <= rxByte;
        end
    end

    // Byte index; 7 selects the byte count on reads and stops writes
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            idx_q <= 3'h0;
        end
        else if (startFlag_q)
        begin
            idx_q <= 3'h0;
        end
        else if (byteDone && readAddr)
        begin
            idx_q <= 3'h7;
        end
        else if (byteDone && state_q == COE_WDAT && idx_q != 3'h7)
        begin
            idx_q <= idx_q + 3'h1;
        end
        else if (byteDone && state_q == COE_RDAT)
        begin
            idx_q <= (idx_q == 3'h7) ? 3'h0 : idx_q + 3'h1;
        end
    end

    // The read address is acknowledged by the device, later read slots by the host
    logic rdAck_q;
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            rdAck_q <= 1'b0;
        end
        else if (startFlag_q || ackEnd)
        begin
            rdAck_q <= 1'b0;
        end
        else if (byteDone)
        begin
            rdAck_q <= readAddr;
        end
    end

    // Enable bytes
    always_ff @(posedge sclClk)
    begin
        if (!sclRstn)
        begin
            enLow_q <= `COE_RST_ENLOW;
            enHigh_q <= `COE_RST_ENHIGH;
        end
        else if (byteDone && state_q == COE_WDAT)
        begin
            if (idx_q == `COE_OFS_ENLOW)
                enLow_q <= mergeByte(rxByte, `COE_ENLOW_RW_MASK, `COE_RST_ENLOW);
            else if (idx_q == `COE_OFS_ENHIGH)
                enHigh_q <= mergeByte(rxByte, `COE_ENHIGH_RW_MASK, `COE_RST_ENHIGH);
        end
    end

    // Data driven on falling scl: ack for write phases, data for reads
    logic [7:0] txByte;
    assign txByte = (idx_q == 3'h7) ? `COE_NUM_BYTES : readByte(idx_q, enLow_q, enHigh_q);
    always_ff @(negedge sclClk)
    begin
        if (!sclRstn)
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end
        else if (startFlag_q || stopFlag_q || state_q == COE_IDLE || state_q == COE_IGN)
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end
        else if (ackPhase_q && (state_q != COE_RDAT || rdAck_q))
        begin
            sdaOe <= 1'b1;
            sdaOut <= 1'b0;
        end
        else if (state_q == COE_RDAT && !ackPhase_q && bitCnt_q <= 4'h7)
        begin
            sdaOe <= ~txByte[3'h7 - bitCnt_q[2:0]];
            sdaOut <= 1'b0;
        end
        else
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

    // Enables into core_clk through two flops
    logic [5:0] enRaw;
    logic [5:0] enSync1_q;
    logic [5:0] enSync2_q;
    assign enRaw = {enLow_q[`COE_BIT_PAIR_A], enLow_q[`COE_BIT_PAIR_B],
                    enLow_q[`COE_BIT_PAIR_C], enLow_q[`COE_BIT_PAIR_D],
                    enHigh_q[`COE_BIT_PAIR_E], enHigh_q[`COE_BIT_PAIR_F]};
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            enSync1_q <= 6'h3f;
            enSync2_q <= 6'h3f;
        end
        else
        begin
            enSync1_q <= enRaw;
            enSync2_q <= enSync1_q;
        end
    end
    assign clockPairEn = enSync2_q;
endmodule

// >>> hdl/coe_map.svh
/*
 Register offsets, reset values and serial bus constants for the clock
 output enable register bank. Included from the package, the register bank module and the bench top.
*/
`ifndef COE_MAP_SVH
`define COE_MAP_SVH
`define COE_NUM_BYTES 8'h07
`define COE_OFS_RSVD0 3'h0
`define COE_OFS_RSVD4 3'h4
`define COE_OFS_ENLOW 3'h5
`define COE_OFS_ENHIGH 3'h6
`define COE_RST_RSVD 8'hff
`define COE_RST_ENLOW 8'hff
`define COE_RST_ENHIGH 8'h1f
`define COE_ENLOW_RW_MASK 8'hcc
`define COE_ENHIGH_RW_MASK 8'h0a
`define COE_BIT_PAIR_A 7
`define COE_BIT_PAIR_B 6
`define COE_BIT_PAIR_C 3
`define COE_BIT_PAIR_D 2
`define COE_BIT_PAIR_E 3
`define COE_BIT_PAIR_F 1
`define COE_ADDR_WRITE 8'hd4
`define COE_ADDR_READ 8'hd5
`endif

// >>> hdl/coe_pkg.sv
/*
 Types for the clock output enable register bank.
 Assumes the constant header sits beside it.
*/
`include "coe_map.svh"
package coe_pkg;
    typedef enum logic [2:0] {
        COE_IDLE = 3'b000,
        COE_ADDR = 3'b001,
        COE_WCMD = 3'b010,
        COE_WCNT = 3'b011,
        COE_WDAT = 3'b100,
        COE_RDAT = 3'b101,
        COE_IGN = 3'b110
    } coe_state_t;
    typedef struct packed {
        logic sclIn;
        logic sdaIn;
    } coe_pins_t;
endpackage

// >>> verif/coe_regs_props.sv
/* Port assertions for coe_regs. Bound to it from the bench top. */
`timescale 1ns/1ps
module coe_regs_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [5:0] clockPairEn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_reset_all_on: assert property ($rose(resetn) |-> clockPairEn == 6'h3f)
        else $error("enables off after reset");
    a_rst_bus_quiet: assert property ($rose(resetn) |-> !sdaOe)
        else $error("data line held after reset");
    a_sda_only_low: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    a_oe_on_fall: assert property ($changed(sdaOe) |-> !sclClk)
        else $error("data line moved with clock high");
    a_ack_full_bit: assert property ($rose(sdaOe) |-> sdaOe[*8])
        else $error("acknowledge too short");
    a_oe_bounded: assert property (sdaOe |-> ##[1:200] !sdaOe)
        else $error("data line held too long");
    a_write_acked: assert property ($changed(clockPairEn) |-> ##[1:24] $rose(sdaOe))
        else $error("enable change without acknowledge");
    a_en_need_scl: assert property ($stable(sclClk)[*6] |-> $stable(clockPairEn))
        else $error("enables moved without bus clock");
    c_ack: cover property ($rose(sdaOe));
    c_all_off: cover property (clockPairEn == 6'h00);
    c_en_change: cover property ($changed(clockPairEn));
endmodule

// >>> verif/coe_host.sv
/* Serial bus host model. Assumes a pull-up on the data line. */
`timescale 1ns/1ps
module coe_host (
    output logic sclClk,
    output logic sdaIn,
    input wire logic sdaOe
);
    logic hostSda = 1'b1;
    assign sdaIn = hostSda & ~sdaOe;
    initial sclClk = 1'b1;
    task automatic bitx(input logic b, output logic s);
        hostSda = b;
        #40 sclClk = 1'b1;
        #40 s = sdaIn;
        #40 sclClk = 1'b0;
        #40;
    endtask
    task automatic start;
        hostSda = 1'b1;
        #40 sclClk = 1'b1;
        #40 hostSda = 1'b0;
        #40 sclClk = 1'b0;
        #40;
    endtask
    task automatic stop;
        hostSda = 1'b0;
        #40 sclClk = 1'b1;
        #40 hostSda = 1'b1;
        #80;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(ackIn, ack);
    endtask
endmodule

// >>> verif/tb_coe_regs.sv
/* Bench top for coe_regs. Host model drives the bus; enables and read-back checked. */
`timescale 1ns/1ps
`include "coe_map.svh"
module tb_coe_regs;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic sclClk, sdaIn, sdaOut, sdaOe, ack;
    logic [5:0] clockPairEn;
    logic [7:0] rx;
    int errorCnt = 0;
    int comparisons = 0;
    coe_regs u_coe_regs (.core_clk(core_clk), .resetn(resetn), .sclClk(sclClk), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .clockPairEn(clockPairEn));
    coe_host u_coe_host (.sclClk(sclClk), .sdaIn(sdaIn), .sdaOe(sdaOe));
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
            errorCnt++;
        end
    endtask
    task automatic wr(input logic [55:0] d, input int n);
        logic [71:0] s;
        s = {8'h5a, 8'h00, d};
        u_coe_host.start();
        u_coe_host.xfer(`COE_ADDR_WRITE, 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00);
        for (int i = 0; i < n + 2; i++)
        begin
            u_coe_host.xfer(s[71 - 8 * i -: 8], 1'b1, rx, ack);
            chk({7'h0, ack}, 8'h00);
        end
        u_coe_host.stop();
    endtask
    task automatic rd(input logic [55:0] e);
        logic [63:0] s;
        s = {8'h07, e};
        u_coe_host.start();
        u_coe_host.xfer(`COE_ADDR_READ, 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            u_coe_host.xfer(8'hff, i == 7, rx, ack);
            chk(rx, s[63 - 8 * i -: 8]);
        end
        u_coe_host.stop();
    endtask
    task automatic t_defaults;
        chk({2'b00, clockPairEn}, 8'h3f);
        rd(56'hffffffffff_ff1f);
        $display("end defaults");
    endtask
    task automatic t_reserved;
        wr(56'h0000000000_33f5, 7);
        chk({2'b00, clockPairEn}, 8'h00);
        rd(56'hffffffffff_3315);
        $display("end reserved");
    endtask
    task automatic t_partial;
        wr(56'h0000000000_88ff, 6);
        chk({2'b00, clockPairEn}, 8'h28);
        wr(56'h0000000000_440a, 7);
        chk({2'b00, clockPairEn}, 8'h17);
        rd(56'hffffffffff_771f);
        $display("end partial");
    endtask
    task automatic t_badaddr;
        u_coe_host.start();
        u_coe_host.xfer(8'ha4, 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h01);
        u_coe_host.stop();
        chk({2'b00, clockPairEn}, 8'h17);
        $display("end bad address");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #600000;
        errorCnt++;
        give_verdict();
    end
    initial
    begin
        // Bus side resets through a synchroniser, so the bus clock runs in reset
        repeat (4) u_coe_host.bitx(1'b1, rx[0]);
        @(negedge core_clk) resetn = 1'b1;
        repeat (2) u_coe_host.bitx(1'b1, rx[0]);
        t_defaults();
        t_reserved();
        t_partial();
        t_badaddr();
        give_verdict();
    end
endmodule
bind coe_regs coe_regs_props u_coe_regs_props (.core_clk(core_clk), .resetn(resetn),
    .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .clockPairEn(clockPairEn));
